/* File: logic/serial_flash_boot_master.sv */
// Serial flash boot master: boot copy, then single-lane read requests
module serial_flash_boot_master
  import sfbm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Flash link
  output logic                   spiClk,
  output logic                   spiMosi,
  input  wire logic              spiMiso,
  output logic                   bootFlashSelectN,
  output logic                   flashSelectN,
  // Rate used for the fast part of boot
  input  wire logic [HALF_W-1:0] bootFastHalf,
  // Program memory write port
  output logic                   memWe,
  output logic [ADDR_W-1:0]      memAddr,
  output logic [7:0]             memData,
  // Boot status
  output logic                   autoInitStart,
  output logic                   bootDone,
  // Read request port after boot
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqSel,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [LEN_W-1:0]  reqLen,
  input  wire logic [HALF_W-1:0] reqHalf,
  output logic                   rdValid,
  output logic [7:0]             rdData
);
  sfbm_state_t       state_reg, state_next;
  sfbm_phase_t       phase_reg, phase_next;
  logic [HALF_W-1:0] half_reg, half_next;
  logic [1:0]        csN_reg, csN_next;
  logic              mosi_reg, mosi_next;
  logic              run_reg, run_next;
  logic [30:0]       shift_reg, shift_next;
  logic [5:0]        cmdCnt_reg, cmdCnt_next;
  logic [2:0]        bitIdx_reg, bitIdx_next;
  logic [7:0]        rx_reg, rx_next;
  logic [LEN_W-1:0]  left_reg, left_next;
  logic [LEN_W-1:0]  bodyLen_reg, bodyLen_next;
  logic [ADDR_W-1:0] wAddr_reg, wAddr_next;
  logic [7:0]        dOut_reg, dOut_next;
  logic              memWe_reg, memWe_next;
  logic              rdV_reg, rdV_next;
  logic              init_reg, init_next;
  logic              done_reg, done_next;
  logic [HALF_W-1:0] gap_reg, gap_next;
  logic              misoMeta_reg, misoSync_reg;
  logic              fallTick;
  logic [7:0]        rxByte;

  // Keep any requested rate inside the legal clock band
  function automatic logic [HALF_W-1:0] clampHalf(input logic [HALF_W-1:0] h);
    if (h < HALF_MIN) return HALF_MIN;
    if (h > HALF_MAX) return HALF_MAX;
    return h;
  endfunction

  // =====================================================================
  // Clock generation
  // Rising ticks are not needed: both launch and capture use the fall
  sfbm_clk_div i_sfbm_clk_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (run_reg),
    .halfCyc  (half_reg),
    .spiClk   (spiClk),
    .riseTick (),
    .fallTick (fallTick)
  );

  // =====================================================================
  // Returned data synchroniser; two cycles late, hence the minimum half
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      misoMeta_reg <= 1'b0;
      misoSync_reg <= 1'b0;
    end else begin
      misoMeta_reg <= spiMiso;
      misoSync_reg <= misoMeta_reg;
    end
  end

  assign rxByte = {rx_reg[6:0], misoSync_reg};

  // =====================================================================
  // Transfer sequencer, next values
  always_comb begin
    state_next   = state_reg;
    phase_next   = phase_reg;
    half_next    = half_reg;
    csN_next     = csN_reg;
    mosi_next    = mosi_reg;
    run_next     = run_reg;
    shift_next   = shift_reg;
    cmdCnt_next  = cmdCnt_reg;
    bitIdx_next  = bitIdx_reg;
    rx_next      = rx_reg;
    left_next    = left_reg;
    bodyLen_next = bodyLen_reg;
    wAddr_next   = wAddr_reg;
    dOut_next    = dOut_reg;
    memWe_next   = 1'b0;
    rdV_next     = 1'b0;
    init_next    = 1'b0;
    done_next    = done_reg;
    gap_next     = gap_reg;
    unique case (state_reg)
      SF_IDLE: begin
        // Boot starts by itself; later transfers wait for a request
        if (phase_reg == PH_HDR) begin
          half_next   = HALF_SLOW;
          csN_next    = CS_BOOT;
          {mosi_next, shift_next} = {CMD_READ, HDR_ADDR};
          left_next   = HDR_BYTES;
          state_next  = SF_XFER;
          run_next    = 1'b1;
        end else if (phase_reg == PH_RUN && reqValid) begin
          if (reqLen != '0) begin
            half_next  = clampHalf(reqHalf);
            csN_next   = reqSel ? 2'h1 : 2'h2;
            {mosi_next, shift_next} = {CMD_READ, reqAddr};
            left_next  = reqLen;
            state_next = SF_XFER;
            run_next   = 1'b1;
          end
        end
        cmdCnt_next = '0;
        bitIdx_next = '0;
      end
      SF_XFER: begin
        if (fallTick) begin
          if (cmdCnt_reg < CMD_LAST) begin
            // Next command or address bit, launched on the fall
            mosi_next   = shift_reg[30];
            shift_next  = {shift_reg[29:0], 1'b0};
            cmdCnt_next = cmdCnt_reg + 6'h1;
          end else if (cmdCnt_reg == CMD_LAST) begin
            mosi_next   = 1'b0;
            cmdCnt_next = CMD_DONE;
          end else begin
            // Flash drove this bit after the previous fall
            rx_next     = rxByte;
            bitIdx_next = bitIdx_reg + 3'h1;
            if (bitIdx_reg == 3'h7) begin
              left_next = left_reg - 24'h1;
              dOut_next = rxByte;
              unique case (phase_reg)
                PH_HDR:  bodyLen_next = {bodyLen_reg[15:0], rxByte};
                PH_BODY: memWe_next   = 1'b1;
                PH_RUN:  rdV_next     = 1'b1;
              endcase
              if (left_reg == 24'h1) begin
                // Release select on the last fall and stop the clock
                csN_next   = CS_IDLE;
                run_next   = 1'b0;
                state_next = SF_GAP;
                gap_next   = '0;
              end
            end
          end
        end
      end
      SF_GAP: begin
        // Select stays high at least one half period between transfers
        gap_next = gap_reg + 4'h1;
        // Clear bit counters so a chained body read sends its command
        cmdCnt_next = '0;
        bitIdx_next = '0;
        if (gap_reg == half_reg) begin
          state_next = SF_IDLE;
          if (phase_reg == PH_HDR) begin
            phase_next = PH_BODY;
            if (bodyLen_reg == '0) begin
              phase_next = PH_RUN;
              init_next  = 1'b1;
              done_next  = 1'b1;
            end else begin
              half_next  = clampHalf(bootFastHalf);
              csN_next   = CS_BOOT;
              {mosi_next, shift_next} = {CMD_READ, BODY_ADDR};
              left_next  = bodyLen_reg;
              state_next = SF_XFER;
              run_next   = 1'b1;
            end
          end else if (phase_reg == PH_BODY) begin
            phase_next = PH_RUN;
            init_next  = 1'b1;
            done_next  = 1'b1;
          end
        end
      end
    endcase
    // Each stored byte moves the write pointer on
    if (memWe_reg) begin
      wAddr_next = wAddr_reg + 24'h1;
    end
  end

  // =====================================================================
  // Transfer sequencer, registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= SF_IDLE;
      phase_reg   <= PH_HDR;
      half_reg    <= HALF_SLOW;
      csN_reg     <= CS_IDLE;
      mosi_reg    <= 1'b0;
      run_reg     <= 1'b0;
      shift_reg   <= '0;
      cmdCnt_reg  <= '0;
      bitIdx_reg  <= '0;
      rx_reg      <= '0;
      left_reg    <= '0;
      bodyLen_reg <= '0;
      wAddr_reg   <= '0;
      dOut_reg    <= '0;
      memWe_reg   <= 1'b0;
      rdV_reg     <= 1'b0;
      init_reg    <= 1'b0;
      done_reg    <= 1'b0;
      gap_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      half_reg    <= half_next;
      csN_reg     <= csN_next;
      mosi_reg    <= mosi_next;
      run_reg     <= run_next;
      shift_reg   <= shift_next;
      cmdCnt_reg  <= cmdCnt_next;
      bitIdx_reg  <= bitIdx_next;
      rx_reg      <= rx_next;
      left_reg    <= left_next;
      bodyLen_reg <= bodyLen_next;
      wAddr_reg   <= wAddr_next;
      dOut_reg    <= dOut_next;
      memWe_reg   <= memWe_next;
      rdV_reg     <= rdV_next;
      init_reg    <= init_next;
      done_reg    <= done_next;
      gap_reg     <= gap_next;
    end
  end

  // =====================================================================
  // Outputs
  assign spiMosi          = mosi_reg;
  assign bootFlashSelectN = csN_reg[0];
  assign flashSelectN     = csN_reg[1];
  assign memWe            = memWe_reg;
  assign memAddr          = wAddr_reg;
  assign memData          = dOut_reg;
  assign rdValid          = rdV_reg;
  assign rdData           = dOut_reg;
  assign autoInitStart    = init_reg;
  assign bootDone         = done_reg;
  assign reqReady         = (state_reg == SF_IDLE) && (phase_reg == PH_RUN);
endmodule // serial_flash_boot_master

/* File: logic/sfbm_clk_div.sv */
// Serial clock divider producing the flash clock and its edge enables
module sfbm_clk_div
  import sfbm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              run,
  input  wire logic [HALF_W-1:0] halfCyc,
  output logic                   spiClk,
  output logic                   riseTick,
  output logic                   fallTick
);
  logic [HALF_W-1:0] cnt_reg;
  logic [HALF_W-1:0] cnt_next;
  logic              sclk_reg;
  logic              sclk_next;
  logic              hit;

  // =====================================================================
  // Half-period counter; clock idles low while not running
  assign hit      = run && (cnt_reg == halfCyc - 4'h1);
  assign riseTick = hit && !sclk_reg;
  assign fallTick = hit && sclk_reg;
  assign spiClk   = sclk_reg;

  always_comb begin
    cnt_next  = cnt_reg;
    sclk_next = sclk_reg;
    if (!run) begin
      cnt_next  = '0;
      sclk_next = 1'b0;
    end else if (hit) begin
      cnt_next  = '0;
      sclk_next = !sclk_reg;
    end else begin
      cnt_next  = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg  <= '0;
      sclk_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      sclk_reg <= sclk_next;
    end
  end
endmodule // sfbm_clk_div

/* File: logic/sfbm_pkg.sv */
// Constants, timing counts and state types of the serial flash boot master
// =====================================================================
package sfbm_pkg;
  // =====================================================================
  // Clock and timing
  localparam int SYS_PERIOD_NS = 40;          // clk_sys at 25 MHz
  localparam int SYNC_STAGES   = 2;           // Input synchroniser depth
  // Slow boot rate: half of the 704 ns longest period, rounded down
  localparam int SLOW_HALF_NS  = 352;
  localparam int SLOW_HALF_CYC = SLOW_HALF_NS / SYS_PERIOD_NS;
  // Fast rate aims at 30 MHz, about 17 ns per half period
  localparam int FAST_HALF_NS  = 17;
  localparam int FAST_HALF_RAW = (FAST_HALF_NS + SYS_PERIOD_NS - 1)
                                 / SYS_PERIOD_NS;
  // Sampling through the synchroniser needs at least two cycles per half
  localparam int MIN_HALF_CYC  = SYNC_STAGES;
  localparam int MAX_HALF_CYC  = SLOW_HALF_CYC;
  localparam int FAST_HALF_CYC = (FAST_HALF_RAW < MIN_HALF_CYC) ?
                                 MIN_HALF_CYC : FAST_HALF_RAW;
  localparam int HALF_W        = 4;
  localparam logic [HALF_W-1:0] HALF_MIN  = 4'(MIN_HALF_CYC);
  localparam logic [HALF_W-1:0] HALF_MAX  = 4'(MAX_HALF_CYC);
  localparam logic [HALF_W-1:0] HALF_SLOW = 4'(SLOW_HALF_CYC);
  localparam logic [HALF_W-1:0] HALF_FAST = 4'(FAST_HALF_CYC);
  // =====================================================================
  // Flash protocol
  localparam int ADDR_W   = 24;
  localparam int LEN_W    = 24;
  localparam int CMD_BITS = 32;
  localparam logic [7:0]        CMD_READ  = 8'h03;
  localparam logic [5:0]        CMD_LAST  = 6'h1F;
  localparam logic [5:0]        CMD_DONE  = 6'h20;
  localparam logic [ADDR_W-1:0] HDR_ADDR  = 24'h000000;
  localparam logic [LEN_W-1:0]  HDR_BYTES = 24'h000003;
  localparam logic [ADDR_W-1:0] BODY_ADDR = 24'h000003;
  localparam logic [1:0]        CS_IDLE   = 2'h3;
  localparam logic [1:0]        CS_BOOT   = 2'h2;  // Select zero low
  // =====================================================================
  // State types
  typedef enum logic [1:0] {SF_IDLE, SF_XFER, SF_GAP} sfbm_state_t;
  typedef enum logic [1:0] {PH_HDR, PH_BODY, PH_RUN} sfbm_phase_t;
endpackage : sfbm_pkg

/* File: verification/serial_flash_boot_master_tb.sv */
// Self-checking bench: boot copy then read requests on both selects
module serial_flash_boot_master_tb
  import sfbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] BOOT_LEN = 8'h04;
  logic              clk_sys = 0, rst = 1, reqValid = 0, reqSel = 0;
  logic              slow = 0, spiMiso, miso0, miso1;
  logic [HALF_W-1:0] bootFastHalf = 4'h2, reqHalf = 4'h2;
  logic [ADDR_W-1:0] reqAddr = '0, memAddr;
  logic [LEN_W-1:0]  reqLen = '0;
  logic              spiClk, spiMosi, bootFlashSelectN, flashSelectN;
  logic              memWe, autoInitStart, bootDone, reqReady, rdValid;
  logic [7:0]        memData, rdData;
  int                errTotal = 0, nTests = 0, inits = 0;
  logic [31:0]       memQ[$];
  logic [7:0]        rdQ[$];
  logic [31:0]       note;
  // ===================================================================
  // Design, two flashes and the shared return line
  serial_flash_boot_master i_serial_flash_boot_master (
    .clk_sys(clk_sys), .rst(rst), .spiClk(spiClk), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .bootFlashSelectN(bootFlashSelectN),
    .flashSelectN(flashSelectN), .bootFastHalf(bootFastHalf),
    .memWe(memWe), .memAddr(memAddr), .memData(memData),
    .autoInitStart(autoInitStart), .bootDone(bootDone),
    .reqValid(reqValid), .reqReady(reqReady), .reqSel(reqSel),
    .reqAddr(reqAddr), .reqLen(reqLen), .reqHalf(reqHalf),
    .rdValid(rdValid), .rdData(rdData));
  sfbm_flash_model #(.KEY(8'h5A), .LEN(BOOT_LEN)) i_sfbm_flash_model (
    .spiClk(spiClk), .selN(bootFlashSelectN), .mosi(spiMosi),
    .slow(slow), .miso(miso0));
  sfbm_flash_model #(.KEY(8'hC3), .LEN(BOOT_LEN)) i_sfbm_flash_model_b (
    .spiClk(spiClk), .selN(flashSelectN), .mosi(spiMosi),
    .slow(slow), .miso(miso1));
  assign spiMiso = !flashSelectN ? miso1 : miso0;
  initial forever #20 clk_sys = ~clk_sys;
  // Expected flash content; keys differ so a wrong select shows
  function automatic logic [7:0] flashByte(logic sel, logic [23:0] a);
    if (a < 2) return 8'h00;
    if (a == 2) return BOOT_LEN;
    return a[7:0] ^ (sel ? 8'hC3 : 8'h5A);
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
    nTests++;
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Output watcher takes the oldest note for each result
  always @(negedge clk_sys) begin
    if (autoInitStart === 1'b1) inits++;
    if (memWe === 1'b1) begin
      note = memQ.size() ? memQ.pop_front() : 'x;
      chk("boot byte", {memAddr, memData}, note);
    end
    if (rdValid === 1'b1) begin
      note = rdQ.size() ? 32'(rdQ.pop_front()) : 'x;
      chk("read byte", 32'(rdData), note);
    end
  end
  // Request held until ready seen, then dropped; wait for all bytes
  task automatic request(logic sel, logic [23:0] a, logic [23:0] n,
                         logic [3:0] h);
    int k;
    for (k = 0; k < n; k++) rdQ.push_back(flashByte(sel, a + 24'(k)));
    @(negedge clk_sys);
    reqSel = sel;
    reqAddr = a;
    reqLen = n;
    reqHalf = h;
    reqValid = 1'b1;
    k = 0;
    while (reqReady !== 1'b1 && k < 5000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("ready wait", k < 5000, 1);
    @(negedge clk_sys);
    reqValid = 1'b0;
    k = 0;
    while (rdQ.size() && k < 20000) begin
      @(negedge clk_sys);
      k++;
    end
    repeat (20) @(negedge clk_sys);
  endtask
  // ===================================================================
  // Main sequence
  initial begin
    int i;
    void'($urandom(32'hC574DD7B));
    // Full 4-bit range so the clamp to the legal band is exercised
    bootFastHalf = 4'($urandom_range(15, 0));
    for (i = 0; i < BOOT_LEN; i++)
      memQ.push_back({24'(i), flashByte(1'b0, 24'(i) + BODY_ADDR)});
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    i = 0;
    while (bootDone !== 1'b1 && i < 20000) begin
      @(negedge clk_sys);
      i++;
    end
    repeat (4) @(negedge clk_sys);
    chk("boot wait", i < 20000, 1);
    chk("boot bytes left", memQ.size(), 0);
    chk("auto init pulses", inits, 1);
    $display("test boot finished");
    for (i = 0; i < 4; i++) begin
      slow = i[1];
      request(i[0], {1'b1, 7'($urandom), 16'($urandom)},
              24'($urandom_range(3, 1)), 4'($urandom_range(15, 0)));
      chk("reads left", rdQ.size(), 0);
      $display("test read %0d finished", i);
    end
    request(1'b0, 24'h000100, 24'h000000, 4'h2);
    chk("idle selects", {bootFlashSelectN, flashSelectN}, 2'h3);
    chk("empty read refused", reqReady, 1);
    $display("test empty read finished");
    testDone;
  end
  initial begin
    #2000000;
    errTotal++;
    $display("watchdog expired");
    testDone;
  end
endmodule // serial_flash_boot_master_tb

/* File: verification/sfbm_checker_props.sv */
// Port assertions for the serial flash boot master
module sfbm_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic spiMosi,
  input wire logic bootFlashSelectN,
  input wire logic flashSelectN,
  input wire logic memWe,
  input wire logic autoInitStart,
  input wire logic bootDone,
  input wire logic reqReady,
  input wire logic rdValid
);
  // ===================================================================
  // Link framing and timing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_mosi_on_low:
    assert property ($changed(spiMosi) |-> !spiClk)
    else $error("data line moved while clock high");
  a_select_on_low:
    assert property ($changed(bootFlashSelectN) |-> !spiClk)
    else $error("select zero moved while clock high");
  a_one_select:
    assert property (bootFlashSelectN || flashSelectN)
    else $error("both selects low");
  a_clock_in_frame:
    assert property ($changed(spiClk) |->
      !$past(bootFlashSelectN) || !$past(flashSelectN))
    else $error("clock moved outside a frame");
  a_high_min:
    assert property ($rose(spiClk) |=> spiClk)
    else $error("clock high phase too short");
  a_high_max:
    assert property ($rose(spiClk) |-> ##[2:8] $fell(spiClk))
    else $error("clock high phase too long");
  a_sample_fall:
    assert property (rdValid |-> !spiClk && $past(spiClk))
    else $error("read byte not after a falling edge");
  // ===================================================================
  // Boot hand-over
  a_we_pulse:
    assert property (memWe |=> !memWe)
    else $error("write pulse too long");
  a_init_done:
    assert property (autoInitStart |=> bootDone && !autoInitStart)
    else $error("auto init not followed by done");
  a_done_holds:
    assert property (bootDone |=> bootDone)
    else $error("boot done dropped");
  a_ready_after:
    assert property (reqReady |-> bootDone)
    else $error("request taken before boot end");
endmodule // sfbm_checker

bind serial_flash_boot_master sfbm_checker i_sfbm_checker (
  .clk_sys(clk_sys), .rst(rst), .spiClk(spiClk), .spiMosi(spiMosi),
  .bootFlashSelectN(bootFlashSelectN), .flashSelectN(flashSelectN),
  .memWe(memWe), .autoInitStart(autoInitStart), .bootDone(bootDone),
  .reqReady(reqReady), .rdValid(rdValid));

/* File: verification/sfbm_flash_model.sv */
// Behavioural serial flash answering single-lane reads
module sfbm_flash_model
  import sfbm_pkg::*;
#(
  parameter logic [7:0] KEY = 8'h5A,
  parameter logic [7:0] LEN = 8'h04
) (
  input  wire logic spiClk,
  input  wire logic selN,
  input  wire logic mosi,
  input  wire logic slow,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt = 0;
  logic [31:0] sh  = '0;
  logic [23:0] a;
  logic [7:0]  b;
  // Command and address shift in on rising edges
  always @(posedge spiClk) begin
    if (!selN && cnt < 32) sh <= {sh[30:0], mosi};
    if (!selN) cnt <= cnt + 1;
  end
  // Deselect restarts; the line shows the inverse so stale data fails
  always @(posedge selN) begin
    cnt <= 0;
    miso <= ~miso;
  end
  // Bits launch after falls; slow mode mimics a long clock-to-output
  always @(negedge spiClk) begin
    if (!selN && cnt >= 32) begin
      a = sh[23:0] + 24'((cnt - 32) / 8);
      b = (a < 2) ? 8'h00 : (a == 2) ? LEN : a[7:0] ^ KEY;
      if (sh[31:24] != CMD_READ) b = ~b;
      miso <= #(slow ? 60 : 5) b[7 - (cnt - 32) % 8];
    end
  end
  initial miso = 1'b0;
endmodule // sfbm_flash_model
